// >>> logic/wpi_image.sv
`timescale 1ns/100ps
// Functional notes
// - eight-word input block placed by node address
// - response 00H idle, 01H executing
// - response 02H done, 03H aborted by error
// - gross is scaled value minus zero offset
// - net is gross minus current tare
// - status bits 3:2 encode range condition
// - status bit 5 set within quarter division
// - bit 6 flags storage error, defaults restored
// - status bit 14 set after first tare
// - input status bits 1:0 are input levels
// - input 1 rising edge triggers tare
// - input 2 rising edge triggers zero
// - output status bits 1:0 are output levels
// - outputs compare net against set points
// - low/high set point pair with hysteresis
// - commands in command byte, progress in response
// - overload when gross exceeds capacity plus nine divisions
module wpi_image #(
	parameter int NODE_BASE = 0
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire wpi_pkg::wpi_params_t params,
	input wire wpi_pkg::wpi_sample_t sample,
	input wire logic nvm_error,
	input wire logic tare_trigger_input,
	input wire logic zero_trigger_input,
	input wire logic [2:0] image_index,
	output logic [15:0] image_word,
	output logic setpoint_one_output,
	output logic setpoint_two_output,
	output logic defaults_restore
);
	// Placement offset only; the interface module maps the block itself
	if (NODE_BASE < 0)
	begin : g_bad_base
		$error("NODE_BASE must not be negative");
	end

	// The three-bit word select serves exactly eight words
	if (wpi_pkg::IN_WORDS != 8)
	begin : g_bad_words
		$error("input block must hold eight words");
	end

	logic [1:0] in_meta_q;
	logic [1:0] in_sync_q;
	logic [1:0] in_prev_q;
	logic signed [31:0] zero_off_q;
	logic signed [31:0] tare_q;
	logic tared_q;
	logic [7:0] resp_q;
	logic [7:0] last_cmd_q;
	wire logic [1:0] out_lvl;
	logic signed [31:0] sp_low [2];
	logic signed [31:0] sp_high [2];
	logic nvm_q;
	logic [15:0] word_q;
	logic signed [31:0] gross_q;
	logic signed [31:0] net_q;
	logic [15:0] status_q;

	// Edge detection on the second stage only
	wire logic tare_edge = in_sync_q[0] & ~in_prev_q[0];
	wire logic zero_edge = in_sync_q[1] & ~in_prev_q[1];
	wire logic cmd_new = (params.command != last_cmd_q);
	wire logic cmd_zero = cmd_new & (params.command == wpi_pkg::CMD_ZERO);
	wire logic cmd_tare = cmd_new & (params.command == wpi_pkg::CMD_TARE);
	wire logic cmd_untare = cmd_new & (params.command == wpi_pkg::CMD_CANCEL_TARE);
	wire logic cmd_reset = cmd_new & (params.command == wpi_pkg::CMD_RESET);
	wire logic cmd_known = cmd_zero | cmd_tare | cmd_untare | cmd_reset;
	// Merged request sources for the zero and tare state
	wire logic tare_event = tare_edge | cmd_tare;
	wire logic clear_all = nvm_error | cmd_reset;

	// Measurement arithmetic
	wire logic signed [31:0] gross_w = sample.scaled - zero_off_q;
	wire logic signed [31:0] net_w = gross_w - tare_q;
	wire logic signed [31:0] abs_gross = gross_w[31] ? -gross_w : gross_w;
	wire logic signed [31:0] ovl_lim = params.capacity
		+ 32'(wpi_pkg::OVL_DIVS) * $signed(params.division);
	wire logic over_cap = (gross_w > params.capacity) || (gross_w < -params.capacity);
	wire logic overload = abs_gross > ovl_lim;
	wire logic near_zero = (abs_gross <<< 2) < $signed(params.division);
	// Zero only honoured inside ten percent of capacity
	wire logic zero_ok = (abs_gross * 10) <= params.capacity;
	wire logic [1:0] range_code = sample.adc_over ? 2'h3
		: ((over_cap | overload) ? 2'h2 : 2'h0);

	// Status word, reserved bits forced low
	logic [15:0] status_w;
	always_comb
	begin
		status_w = 16'h0000;
		status_w[wpi_pkg::ST_RANGE_HI:wpi_pkg::ST_RANGE_LO] = range_code;
		status_w[wpi_pkg::ST_NEAR_ZERO] = near_zero;
		status_w[wpi_pkg::ST_NVM_ERR] = nvm_q;
		status_w[wpi_pkg::ST_IN1] = in_sync_q[0];
		status_w[wpi_pkg::ST_IN2] = in_sync_q[1];
		status_w[wpi_pkg::ST_SETPOINT_ONE_OUTPUT] = out_lvl[0];
		status_w[wpi_pkg::ST_SETPOINT_TWO_OUTPUT] = out_lvl[1];
		status_w[wpi_pkg::ST_TARED] = tared_q;
	end

	// Word mux for the input block
	logic [15:0] word_w;
	always_comb
	begin
		unique case (image_index)
			wpi_pkg::W_RESP: word_w = {8'h00, resp_q};
			wpi_pkg::W_DIN: word_w = {14'h0000, in_sync_q};
			wpi_pkg::W_GROSS_HI: word_w = gross_q[31:16];
			wpi_pkg::W_GROSS_LO: word_w = gross_q[15:0];
			wpi_pkg::W_STATUS: word_w = status_q;
			wpi_pkg::W_NET_HI: word_w = net_q[31:16];
			wpi_pkg::W_NET_LO: word_w = net_q[15:0];
			default: word_w = {14'h0000, out_lvl};
		endcase
	end

	// Two-stage input synchroniser
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			in_meta_q <= 2'h0;
			in_sync_q <= 2'h0;
			in_prev_q <= 2'h0;
		end
		else
		begin
			in_meta_q <= {zero_trigger_input, tare_trigger_input};
			in_sync_q <= in_meta_q;
			in_prev_q <= in_sync_q;
		end
	end

	// Zero and tare state; pin and command requests merge here
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			zero_off_q <= 32'h00000000;
			tare_q <= 32'h00000000;
		end
		else if (clear_all)
		begin
			zero_off_q <= 32'h00000000;
			tare_q <= 32'h00000000;
		end
		else
		begin
			if ((zero_edge || cmd_zero) && zero_ok)
				zero_off_q <= sample.scaled;
			if (tare_event)
				tare_q <= gross_w;
			else if (cmd_untare)
				tare_q <= 32'h00000000;
		end
	end

	// Tare-seen flag; a tare in the clearing cycle still counts
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			tared_q <= 1'b0;
		else if (tare_event)
			tared_q <= 1'b1;
		else if (clear_all)
			tared_q <= 1'b0;
	end

	// Completion verdict; refused zero and unknown codes end in error
	wire logic cmd_refused = nvm_q || (params.command == wpi_pkg::CMD_ZERO && !zero_ok);
	wire logic cmd_listed = params.command inside {wpi_pkg::CMD_ZERO,
		wpi_pkg::CMD_TARE, wpi_pkg::CMD_CANCEL_TARE, wpi_pkg::CMD_RESET};
	wire logic [7:0] resp_verdict = (cmd_refused || !cmd_listed)
		? wpi_pkg::RSP_ERROR : wpi_pkg::RSP_DONE;

	// Command progress; each command completes in one cycle after acceptance
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			resp_q <= wpi_pkg::RSP_IDLE;
			last_cmd_q <= wpi_pkg::CMD_NONE;
		end
		else
		begin
			last_cmd_q <= params.command;
			if (params.command == wpi_pkg::CMD_NONE)
				resp_q <= wpi_pkg::RSP_IDLE;
			else if (cmd_new)
				resp_q <= wpi_pkg::RSP_BUSY;
			else if (resp_q == wpi_pkg::RSP_BUSY)
				resp_q <= resp_verdict;
		end
	end

	// Set-point pairs, one per output
	assign sp_low[0] = params.sp1_low;
	assign sp_high[0] = params.sp1_high;
	assign sp_low[1] = params.sp2_low;
	assign sp_high[1] = params.sp2_high;

	// Hysteresis per output; between the two points the level holds
	for (genvar g = 0; g < 2; g++)
	begin : g_setpoint
		wire logic rise_w = net_w >= sp_high[g];
		wire logic fall_w = net_w < sp_low[g];
		logic lvl_q;
		always_ff @(posedge core_clk or negedge rst_n)
		begin
			if (!rst_n)
				lvl_q <= 1'b0;
			else if (rise_w)
				lvl_q <= 1'b1;
			else if (fall_w)
				lvl_q <= 1'b0;
		end
		assign out_lvl[g] = lvl_q;
	end

	// Registered image and pins
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			nvm_q <= 1'b0;
			gross_q <= 32'h00000000;
			net_q <= 32'h00000000;
			status_q <= 16'h0000;
			word_q <= 16'h0000;
		end
		else
		begin
			nvm_q <= nvm_error;
			if (sample.valid)
			begin
				gross_q <= gross_w;
				net_q <= net_w;
			end
			status_q <= status_w;
			word_q <= word_w;
		end
	end

	assign image_word = word_q;
	assign setpoint_one_output = out_lvl[0];
	assign setpoint_two_output = out_lvl[1];
	assign defaults_restore = nvm_q;
endmodule : wpi_image

// >>> logic/wpi_pkg.sv
package wpi_pkg;
	// Response codes of the command state byte
	localparam logic [7:0] RSP_IDLE = 8'h00;
	localparam logic [7:0] RSP_BUSY = 8'h01;
	localparam logic [7:0] RSP_DONE = 8'h02;
	localparam logic [7:0] RSP_ERROR = 8'h03;
	// Command codes written into the command byte
	localparam logic [7:0] CMD_NONE = 8'h00;
	localparam logic [7:0] CMD_RESET = 8'hD0;
	localparam logic [7:0] CMD_ZERO = 8'hD3;
	localparam logic [7:0] CMD_TARE = 8'hD4;
	localparam logic [7:0] CMD_CANCEL_TARE = 8'hD5;
	// Word indices inside the eight-word input block
	localparam int IN_WORDS = 8;
	localparam int OUT_WORDS = 11;
	localparam logic [2:0] W_RESP = 3'h0;
	localparam logic [2:0] W_DIN = 3'h1;
	localparam logic [2:0] W_GROSS_HI = 3'h2;
	localparam logic [2:0] W_GROSS_LO = 3'h3;
	localparam logic [2:0] W_STATUS = 3'h4;
	localparam logic [2:0] W_NET_HI = 3'h5;
	localparam logic [2:0] W_NET_LO = 3'h6;
	localparam logic [2:0] W_DOUT = 3'h7;
	// Status word bit positions
	localparam int ST_RANGE_LO = 2;
	localparam int ST_RANGE_HI = 3;
	localparam int ST_NEAR_ZERO = 5;
	localparam int ST_NVM_ERR = 6;
	localparam int ST_IN1 = 8;
	localparam int ST_IN2 = 9;
	localparam int ST_SETPOINT_ONE_OUTPUT = 10;
	localparam int ST_SETPOINT_TWO_OUTPUT = 11;
	localparam int ST_TARED = 14;
	// Overload margin in divisions
	localparam int OVL_DIVS = 9;
	// Parameter set carried from the output block
	typedef struct packed {
		logic [7:0] command;
		logic signed [31:0] capacity;
		logic [31:0] division;
		logic signed [31:0] sp1_low;
		logic signed [31:0] sp1_high;
		logic signed [31:0] sp2_low;
		logic signed [31:0] sp2_high;
	} wpi_params_t;
	// Measurement snapshot from the converter front end
	typedef struct packed {
		logic valid;
		logic adc_over;
		logic signed [31:0] scaled;
	} wpi_sample_t;
endpackage : wpi_pkg

// >>> sim/weighing_process_image_bench.sv
`timescale 1ns/100ps
module weighing_process_image_bench;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic nvm_error = 1'b0;
	logic tin = 1'b0;
	logic zin = 1'b0;
	logic dr;
	logic so1;
	logic so2;
	logic [2:0] idx;
	logic [15:0] word;
	// Output block words held by the bench in the interface's place
	wpi_pkg::wpi_params_t prm = {8'h00, 32'h186A0, 32'h1, 32'h64, 32'hC8, 32'h7530, 32'h9C40};
	wpi_pkg::wpi_sample_t smp_r = '0;
	int num_errors = 0;
	int num_checks = 0;
	int cyc = 0;
	always #20 core_clk = ~core_clk;
	wpi_image u_dut (.core_clk, .rst_n, .params(prm), .sample(smp_r), .nvm_error,
		.tare_trigger_input(tin), .zero_trigger_input(zin), .image_index(idx), .image_word(word),
		.setpoint_one_output(so1), .setpoint_two_output(so2), .defaults_restore(dr));
	wpi_nim_model u_nim (.core_clk, .rst_n, .image_word(word), .image_index(idx));
	task complete_run;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : complete_run
	task ck(input string n, input logic [15:0] s, input logic [15:0] e);
		num_checks++;
		if (s !== e)
		begin
			num_errors++;
			$display("Error %s exp %h seen %h", n, e, s);
		end
	endtask : ck
	// Wait past one full scan, then read the stored word
	task rd(input logic [2:0] i, input logic [15:0] m, input logic [15:0] e);
		repeat (12) @(posedge core_clk);
		ck($sformatf("word%0d", i), u_nim.img[i] & m, e);
	endtask : rd
	task cmd(input logic [7:0] c);
		@(posedge core_clk);
		prm.command <= c;
	endtask : cmd
	task smp(input logic [31:0] v, input logic o);
		@(posedge core_clk);
		smp_r <= {1'b1, o, v};
		@(posedge core_clk);
		smp_r.valid <= 1'b0;
	endtask : smp
	// Hang guard
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			num_errors++;
			complete_run();
		end
	end
	initial
	begin
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(3'h4, 16'h4000, 16'h0000);
		smp(32'h3E8, 1'b0);
		rd(3'h3, 16'hFFFF, 16'h03E8);
		rd(3'h6, 16'hFFFF, 16'h03E8);
		rd(3'h4, 16'h000C, 16'h0000);
		rd(3'h7, 16'hFFFF, 16'h0001);
		ck("sp1", {15'h0, so1}, 16'h0001);
		cmd(8'hD4);
		rd(3'h0, 16'hFFFF, 16'h0002);
		smp(32'h3E8, 1'b0);
		rd(3'h6, 16'hFFFF, 16'h0000);
		rd(3'h4, 16'h4000, 16'h4000);
		rd(3'h7, 16'hFFFF, 16'h0000);
		cmd(8'h00);
		rd(3'h0, 16'hFFFF, 16'h0000);
		cmd(8'h77);
		rd(3'h0, 16'hFFFF, 16'h0003);
		cmd(8'h00);
		cmd(8'hD0);
		rd(3'h0, 16'hFFFF, 16'h0002);
		smp(32'h3E8, 1'b0);
		rd(3'h6, 16'hFFFF, 16'h03E8);
		cmd(8'h00);
		cmd(8'hD3);
		smp(32'h3E8, 1'b0);
		rd(3'h3, 16'hFFFF, 16'h0000);
		smp(32'h5DC, 1'b0);
		tin <= 1'b1;
		rd(3'h1, 16'hFFFF, 16'h0001);
		smp(32'h5DC, 1'b0);
		rd(3'h6, 16'hFFFF, 16'h0000);
		zin <= 1'b1;
		rd(3'h1, 16'hFFFF, 16'h0003);
		smp(32'h5DC, 1'b0);
		rd(3'h3, 16'hFFFF, 16'h0000);
		smp(32'h30D40, 1'b0);
		rd(3'h4, 16'h000C, 16'h0008);
		rd(3'h7, 16'hFFFF, 16'h0003);
		ck("sp2", {15'h0, so2}, 16'h0001);
		smp(32'h30D40, 1'b1);
		rd(3'h4, 16'h000C, 16'h000C);
		nvm_error <= 1'b1;
		rd(3'h4, 16'h0040, 16'h0040);
		ck("restore", {15'h0, dr}, 16'h0001);
		complete_run();
	end
endmodule : weighing_process_image_bench

// >>> sim/wpi_image_props.sv
`timescale 1ns/100ps
// Port checks; scanning partner keeps every index visited
module wpi_image_props (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire wpi_pkg::wpi_params_t params,
	input wire wpi_pkg::wpi_sample_t sample,
	input wire logic nvm_error,
	input wire logic tare_trigger_input,
	input wire logic zero_trigger_input,
	input wire logic [2:0] image_index,
	input wire logic [15:0] image_word,
	input wire logic setpoint_one_output,
	input wire logic setpoint_two_output,
	input wire logic defaults_restore
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence s_err; nvm_error [*3]; endsequence
	sequence s_ok; !nvm_error [*3]; endsequence
	sequence s_idle; (params.command == wpi_pkg::CMD_NONE) [*4]; endsequence
	property p_boot; $rose(rst_n) |-> image_word == 16'h0000; endproperty
	property p_idle; s_idle ##0 $past(image_index) == wpi_pkg::W_RESP |-> image_word == 16'h0000;
	endproperty
	property p_resp; $past(image_index) == wpi_pkg::W_RESP |-> image_word <= 16'h0003; endproperty
	property p_rsv; $past(image_index) == wpi_pkg::W_STATUS |-> (image_word & 16'hB093) == 16'h0;
	endproperty
	property p_din; $past(image_index) == wpi_pkg::W_DIN |-> image_word[15:2] == 14'h0; endproperty
	property p_dout; $past(image_index) == wpi_pkg::W_DOUT |-> image_word[15:2] == 14'h0;
	endproperty
	property p_nvm_on; s_err |-> defaults_restore; endproperty
	property p_nvm_off; s_ok |-> !defaults_restore; endproperty
	a_boot: assert property (p_boot) else $error("word not clear after reset");
	a_idle: assert property (p_idle) else $error("response not idle");
	a_resp: assert property (p_resp) else $error("response code out of set");
	a_rsv: assert property (p_rsv) else $error("reserved status bit set");
	a_din: assert property (p_din) else $error("input status upper bits set");
	a_dout: assert property (p_dout) else $error("output status upper bits set");
	a_nvm_on: assert property (p_nvm_on) else $error("restore flag missing");
	a_nvm_off: assert property (p_nvm_off) else $error("restore flag stuck");
endmodule : wpi_image_props

bind wpi_image wpi_image_props u_props (.core_clk, .rst_n, .params, .sample, .nvm_error,
	.tare_trigger_input, .zero_trigger_input, .image_index, .image_word,
	.setpoint_one_output, .setpoint_two_output, .defaults_restore);

// >>> sim/wpi_nim_model.sv
`timescale 1ns/100ps
// Island interface model: scans the input block round robin
module wpi_nim_model (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [15:0] image_word,
	output logic [2:0] image_index
);
	logic [2:0] prev_q;
	logic [15:0] img [8];
	// Word lands one cycle after its index, so store under the old index
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			image_index <= 3'h0;
			prev_q <= 3'h0;
		end
		else
		begin
			image_index <= image_index + 3'h1;
			prev_q <= image_index;
			img[prev_q] <= image_word;
		end
	end
endmodule : wpi_nim_model
